// ===== hw/dci_core.v
// Control and I/O instruction decoder with external bus strobes.
`timescale 1ns/100ps
`default_nettype none
`include "dci_map.vh"
module dci_core #(
	parameter RAM_WORDS = `DCI_RAM_WORDS,
	parameter AW        = `DCI_PMEM_AW
) (
	// Clock and reset.
	input  wire        SYS_CLK_I,
	input  wire        RST_B_I,
	// External bus.
	input  wire [15:0] DATA_I,
	output reg  [15:0] DATA_O,
	output reg         DATA_OE_B_O,
	output reg  [11:0] ADDR_O,
	output reg         PORT_READ_STROBE_B_O,
	output reg         WRITE_STROBE_B_O,
	output reg         FETCH_STROBE_B_O,
	output reg         SYSTEM_CLOCK_O,
	// Pins from outside.
	input  wire        MEMORY_MAP_SELECT_I,
	input  wire        IRQ_B_I,
	input  wire        POLL_FLAG_I,
	// Accumulator link and state.
	input  wire [15:0] ACC_I,
	output reg  [15:0] ACC_O,
	output reg         ACC_LOAD_O,
	output reg  [15:0] STATUS_O,
	output reg         IRQ_MASK_O,
	output reg         SATURATE_O,
	output reg         MICROCOMPUTER_O,
	output reg         IRQ_PEND_O,
	output reg         POLL_O,
	output reg  [11:0] PC_O
);
	localparam ST_FETCH = 2'h0;
	localparam ST_EXEC  = 2'h1;
	localparam ST_LAST  = 2'h2;
	localparam [7:0] RAM_LAST = RAM_WORDS - 1;

	wire        phase_en;
	wire        clk_q;
	reg  [15:0] ram [0:RAM_WORDS-1];
	reg  [15:0] stk [0:`DCI_STACK_DEPTH-1];
	reg  [1:0]  sp_reg;
	reg  [1:0]  state_reg;
	reg  [1:0]  cyc_reg;
	reg  [15:0] ir_reg;
	reg  [15:0] tmp_reg;
	reg  [2:0]  mode_s_reg;
	reg  [2:0]  irq_s_reg;
	reg  [2:0]  poll_s_reg;
	reg  [7:0]  dad;
	reg  [7:0]  ex_dad;

	// Address clipped into the RAM; the top words alias onto the last.
	function [7:0] clip;
		input [7:0] a;
		begin
			clip = (a >= RAM_WORDS) ? RAM_LAST : a;
		end
	endfunction

	function [1:0] cycles;
		input [15:0] op;
		begin
			if (op[15:11] == `DCI_HI5_PIN || op[15:11] == `DCI_HI5_POUT ||
				op == `DCI_OP_POP || op == `DCI_OP_PUSH)
				cycles = `DCI_CYC_TWO;
			else if (op[15:8] == `DCI_HI_PRG2RAM ||
				op[15:8] == `DCI_HI_RAM2PRG)
				cycles = `DCI_CYC_THREE;
			else
				cycles = `DCI_CYC_ONE;
		end
	endfunction

	dci_clkdiv u_div (
		.clk_i      (SYS_CLK_I),
		.rst_b_i    (RST_B_I),
		.phase_en_o (phase_en),
		.clk_out_o  (clk_q)
	);

	always @* begin
		dad    = clip({1'b0, ir_reg[6:0]});
		ex_dad = clip({1'b0, DATA_I[6:0]});
	end

	// Pins from outside pass three flops before use.
	always @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mode_s_reg <= 3'h0;
			irq_s_reg  <= 3'h7;
			poll_s_reg <= 3'h0;
		end else begin
			mode_s_reg <= {mode_s_reg[1:0], MEMORY_MAP_SELECT_I};
			irq_s_reg  <= {irq_s_reg[1:0], IRQ_B_I};
			poll_s_reg <= {poll_s_reg[1:0], POLL_FLAG_I};
		end
	end

	// Single-cycle RAM ops act on the word being executed, so that the
	// next instruction already sees their result.
	always @(posedge SYS_CLK_I) begin
		if (phase_en && state_reg == ST_EXEC) begin
			case (DATA_I[15:8])
			`DCI_HI_SHIFTUP: begin
				if (ex_dad < RAM_LAST)
					ram[ex_dad + 8'h01] <= ram[ex_dad];
			end
			`DCI_HI_STSAVE: ram[ex_dad] <= STATUS_O;
			default: ;
			endcase
		end
		if (phase_en && state_reg == ST_LAST && cyc_reg == `DCI_CYC_TWO &&
			(ir_reg[15:8] == `DCI_HI_PRG2RAM ||
			ir_reg[15:11] == `DCI_HI5_PIN))
			ram[dad] <= DATA_I;
	end

	// One phase_en per machine cycle; multi-cycle ops walk EXEC then LAST.
	always @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_reg            <= ST_FETCH;
			cyc_reg              <= 2'h0;
			ir_reg               <= `DCI_OP_NOP;
			tmp_reg              <= 16'h0000;
			sp_reg               <= 2'h0;
			PC_O                 <= 12'h000;
			ADDR_O               <= 12'h000;
			DATA_O               <= 16'h0000;
			DATA_OE_B_O          <= 1'b1;
			PORT_READ_STROBE_B_O <= 1'b1;
			WRITE_STROBE_B_O     <= 1'b1;
			FETCH_STROBE_B_O     <= 1'b1;
			SYSTEM_CLOCK_O       <= 1'b0;
			ACC_O                <= 16'h0000;
			ACC_LOAD_O           <= 1'b0;
			STATUS_O             <= `DCI_STATUS_RST;
			IRQ_MASK_O           <= 1'b1;
			SATURATE_O           <= 1'b0;
			MICROCOMPUTER_O      <= 1'b0;
			IRQ_PEND_O           <= 1'b0;
			POLL_O               <= 1'b0;
		end else begin
			SYSTEM_CLOCK_O  <= clk_q;
			MICROCOMPUTER_O <= mode_s_reg[2];
			IRQ_PEND_O      <= ~irq_s_reg[2] & ~IRQ_MASK_O;
			POLL_O          <= poll_s_reg[2];
			ACC_LOAD_O      <= 1'b0;
			if (phase_en) begin
				PORT_READ_STROBE_B_O <= 1'b1;
				WRITE_STROBE_B_O     <= 1'b1;
				FETCH_STROBE_B_O     <= 1'b1;
				DATA_OE_B_O          <= 1'b1;
				case (state_reg)
				ST_FETCH: begin
					// Full-rate fetch: the word is taken on the next enable.
					ADDR_O           <= PC_O;
					FETCH_STROBE_B_O <= 1'b0;
					state_reg        <= ST_EXEC;
				end
				ST_EXEC: begin
					ir_reg <= DATA_I;
					PC_O   <= PC_O + 12'h001;
					cyc_reg <= cycles(DATA_I);
					state_reg <= (cycles(DATA_I) == `DCI_CYC_ONE) ?
						ST_FETCH : ST_LAST;
					case (DATA_I)
					`DCI_OP_IRQ_SET: IRQ_MASK_O <= 1'b1;
					`DCI_OP_IRQ_CLR: IRQ_MASK_O <= 1'b0;
					`DCI_OP_SAT_OFF: SATURATE_O <= 1'b0;
					`DCI_OP_SAT_ON:  SATURATE_O <= 1'b1;
					`DCI_OP_PUSH: begin
						stk[sp_reg] <= ACC_I;
						sp_reg      <= sp_reg + 2'h1;
					end
					`DCI_OP_POP: begin
						tmp_reg <= stk[sp_reg - 2'h1];
						sp_reg  <= sp_reg - 2'h1;
					end
					default: begin
						if (DATA_I[15:8] == `DCI_HI_STLOAD)
							STATUS_O <= ram[clip({1'b0, DATA_I[6:0]})];
						if (DATA_I[15:11] == `DCI_HI5_PIN) begin
							ADDR_O <= {9'h000, DATA_I[10:8]};
							PORT_READ_STROBE_B_O <= 1'b0;
						end
						if (DATA_I[15:11] == `DCI_HI5_POUT) begin
							ADDR_O <= {9'h000, DATA_I[10:8]};
							DATA_O <= ram[clip({1'b0, DATA_I[6:0]})];
							DATA_OE_B_O      <= 1'b0;
							WRITE_STROBE_B_O <= 1'b0;
						end
						if (DATA_I[15:8] == `DCI_HI_PRG2RAM ||
							DATA_I[15:8] == `DCI_HI_RAM2PRG)
							tmp_reg <= ACC_I;
					end
					endcase
				end
				ST_LAST: begin
					cyc_reg <= cyc_reg - 2'h1;
					if (cyc_reg == `DCI_CYC_TWO) begin
						state_reg <= ST_FETCH;
						if (ir_reg == `DCI_OP_POP) begin
							ACC_O      <= tmp_reg;
							ACC_LOAD_O <= 1'b1;
						end
					end else if (ir_reg[15:8] == `DCI_HI_PRG2RAM) begin
						ADDR_O           <= tmp_reg[11:0];
						FETCH_STROBE_B_O <= 1'b0;
					end else begin
						ADDR_O           <= tmp_reg[11:0];
						DATA_O           <= ram[dad];
						DATA_OE_B_O      <= 1'b0;
						WRITE_STROBE_B_O <= 1'b0;
					end
				end
				default: state_reg <= ST_FETCH;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== common/dci_map.vh
// Constants for the control and I/O instruction decoder.
`ifndef DCI_MAP_VH
`define DCI_MAP_VH
`define DCI_RAM_WORDS      144
`define DCI_PMEM_AW        12
`define DCI_CLK_DIV        4
`define DCI_OP_IRQ_SET     16'h7F81
`define DCI_OP_IRQ_CLR     16'h7F82
`define DCI_OP_NOP         16'h7F80
`define DCI_OP_POP         16'h7F9D
`define DCI_OP_PUSH        16'h7F9C
`define DCI_OP_SAT_OFF     16'h7F8A
`define DCI_OP_SAT_ON      16'h7F8B
`define DCI_HI_STLOAD      8'h7B
`define DCI_HI_STSAVE      8'h7C
`define DCI_HI_SHIFTUP     8'h69
`define DCI_HI_PRG2RAM     8'h67
`define DCI_HI_RAM2PRG     8'h7D
`define DCI_HI5_PIN        5'h08
`define DCI_HI5_POUT       5'h09
`define DCI_CYC_ONE        2'h0
`define DCI_CYC_TWO        2'h1
`define DCI_CYC_THREE      2'h2
`define DCI_STATUS_RST     16'h0000
`define DCI_STACK_DEPTH    4
`endif

// ===== hw/dci_clkdiv.v
// Divide-by-four clock enable and system clock output generator.
`timescale 1ns/100ps
`default_nettype none
`include "dci_map.vh"
module dci_clkdiv #(
	parameter DIV = `DCI_CLK_DIV
) (
	input  wire       clk_i,
	input  wire       rst_b_i,
	output reg        phase_en_o,
	output reg        clk_out_o
);
	reg [1:0] cnt_reg;

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg    <= 2'h0;
			phase_en_o <= 1'b0;
			clk_out_o  <= 1'b0;
		end else begin
			cnt_reg    <= cnt_reg + 2'h1;
			phase_en_o <= (cnt_reg == 2'h3);
			clk_out_o  <= (cnt_reg < 2'h2);
		end
	end
endmodule
`default_nettype wire

// ===== sim/dci_monitor.sv
// Concurrent checks on the decoder's strobes, clock output and pins.
`timescale 1ns/100ps
`default_nettype none
module dci_mon (
	// Clock, reset and pins.
	input wire logic        SYS_CLK_I,
	input wire logic        RST_B_I,
	input wire logic        MEMORY_MAP_SELECT_I,
	// Watched outputs.
	input wire logic        DATA_OE_B_O,
	input wire logic        PORT_READ_STROBE_B_O,
	input wire logic        WRITE_STROBE_B_O,
	input wire logic        FETCH_STROBE_B_O,
	input wire logic        SYSTEM_CLOCK_O,
	input wire logic        MICROCOMPUTER_O,
	input wire logic        IRQ_MASK_O,
	input wire logic [11:0] ADDR_O,
	input wire logic [11:0] PC_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);
	property p_clk_div;
		$changed(SYSTEM_CLOCK_O) |=> $stable(SYSTEM_CLOCK_O) ##1
			$changed(SYSTEM_CLOCK_O);
	endproperty
	a_clk_div: assert property (p_clk_div) else $error("clock out");
	property p_fetch_len;
		$fell(FETCH_STROBE_B_O) |-> !FETCH_STROBE_B_O [*4];
	endproperty
	a_fetch_len: assert property (p_fetch_len) else $error("fetch");
	property p_read_len;
		$fell(PORT_READ_STROBE_B_O) |-> !PORT_READ_STROBE_B_O [*4];
	endproperty
	a_read_len: assert property (p_read_len) else $error("read");
	property p_write_len;
		$fell(WRITE_STROBE_B_O) |-> !WRITE_STROBE_B_O [*4];
	endproperty
	a_write_len: assert property (p_write_len) else $error("write");
	property p_write_oe;
		!WRITE_STROBE_B_O |-> !DATA_OE_B_O;
	endproperty
	a_write_oe: assert property (p_write_oe) else $error("bus oe");
	property p_port_addr;
		!PORT_READ_STROBE_B_O && !$past(PORT_READ_STROBE_B_O) |-> $stable(ADDR_O);
	endproperty
	a_port_addr: assert property (p_port_addr) else $error("addr");
	property p_mode;
		$changed(MEMORY_MAP_SELECT_I) |-> ##[1:5]
			MICROCOMPUTER_O == MEMORY_MAP_SELECT_I;
	endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_reset;
		$rose(RST_B_I) |-> IRQ_MASK_O && PC_O == 12'h000 && FETCH_STROBE_B_O;
	endproperty
	a_reset: assert property (p_reset) else $error("reset");
endmodule
bind dci_core dci_mon mon_u (.SYS_CLK_I, .RST_B_I, .MEMORY_MAP_SELECT_I,
	.DATA_OE_B_O, .PORT_READ_STROBE_B_O, .WRITE_STROBE_B_O,
	.FETCH_STROBE_B_O, .SYSTEM_CLOCK_O, .MICROCOMPUTER_O, .IRQ_MASK_O,
	.ADDR_O, .PC_O);
`default_nettype wire

// ===== sim/dci_ext_mem.sv
// External program memory and port device model.
`timescale 1ns/100ps
`default_nettype none
module dci_ext_mem (
	// Bus controls.
	input  wire logic        clk_i,
	input  wire logic        fetch_b_i,
	input  wire logic        rd_b_i,
	input  wire logic [11:0] addr_i,
	// Port value and bus drive.
	input  wire logic [15:0] port_i,
	output var  logic [15:0] data_o
);
	logic [15:0] pm [0:127];
	initial data_o = 16'h0000;
	// A released bus toggles so a stale word is never mistaken for data.
	always @(posedge clk_i) begin
		if (!fetch_b_i)
			data_o <= pm[addr_i[6:0]];
		else if (!rd_b_i)
			data_o <= port_i;
		else
			data_o <= ~data_o;
	end
endmodule
`default_nettype wire

// ===== sim/dci_core_tb.sv
// Self-checking bench for the control and I/O decoder.
`timescale 1ns/100ps
`default_nettype none
`include "dci_map.vh"
module dci_core_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        map_sel = 1'b0;
	logic        poll = 1'b0;
	logic [15:0] acc_in = 16'h0000;
	logic [15:0] port_val = 16'h0000;
	wire  [15:0] dout, mem_out, acc_o;
	wire  [11:0] addr;
	wire  [15:0] st;
	wire         oe_b, rd_b, wr_b, fe_b, acc_ld, mask, sat, mc, pl;
	wire  [15:0] bus = oe_b ? mem_out : dout;
	logic [19:0] q [$];
	logic [15:0] prog [0:15];
	logic [15:0] a, d, w;
	logic        wr_d = 1'b1;
	integer      seed = 32'hfe3b;
	integer      err_total = 0;
	integer      samples_checked = 0;
	integer      cyc = 0;
	integer      i;
	always #5 clk = ~clk;
	dci_core dut_u (.SYS_CLK_I(clk), .RST_B_I(rst_b), .DATA_I(bus),
		.DATA_O(dout), .DATA_OE_B_O(oe_b), .ADDR_O(addr),
		.PORT_READ_STROBE_B_O(rd_b), .WRITE_STROBE_B_O(wr_b),
		.FETCH_STROBE_B_O(fe_b), .SYSTEM_CLOCK_O(),
		.MEMORY_MAP_SELECT_I(map_sel), .IRQ_B_I(1'b1), .POLL_FLAG_I(poll),
		.ACC_I(acc_in), .ACC_O(acc_o), .ACC_LOAD_O(acc_ld), .STATUS_O(st),
		.IRQ_MASK_O(mask), .SATURATE_O(sat), .MICROCOMPUTER_O(mc),
		.IRQ_PEND_O(), .POLL_O(pl), .PC_O());
	dci_ext_mem pm_u (.clk_i(clk), .fetch_b_i(fe_b), .rd_b_i(rd_b),
		.addr_i(addr), .port_i(port_val), .data_o(mem_out));
	task check(input string nm, input logic [19:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task summarize;
		$display("Checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			summarize;
		end
	end
	// Sampled on the falling edge so design registers have settled.
	always @(negedge clk) begin
		wr_d <= wr_b;
		if (!wr_b && wr_d)
			check("write", {1'b0, addr[2:0], dout}, q.pop_front());
		if (acc_ld)
			check("pop", {4'h8, acc_o}, q.pop_front());
	end
	initial begin
		a = $random(seed);
		d = $random(seed);
		w = $random(seed);
		a[6:5] = 2'b11;
		prog = '{{`DCI_HI5_PIN, 3'h3, 8'h0A}, {`DCI_HI5_POUT, 3'h5, 8'h0A},
			{`DCI_HI_SHIFTUP, 8'h0A}, {`DCI_HI5_POUT, 3'h2, 8'h0B},
			{`DCI_HI_STLOAD, 8'h0A}, {`DCI_HI_STSAVE, 8'h0C},
			{`DCI_HI5_POUT, 3'h7, 8'h0C}, `DCI_OP_PUSH, `DCI_OP_POP,
			`DCI_OP_SAT_ON, `DCI_OP_IRQ_CLR, {`DCI_HI_PRG2RAM, 8'h0D},
			{`DCI_HI5_POUT, 3'h1, 8'h0D}, {`DCI_HI_RAM2PRG, 8'h0D},
			`DCI_OP_IRQ_SET, `DCI_OP_SAT_OFF};
		for (i = 0; i < 128; i++)
			pm_u.pm[i] = (i < 16) ? prog[i] : `DCI_OP_NOP;
		pm_u.pm[a[6:0]] = w;
		q = '{{4'h5, d}, {4'h2, d}, {4'h7, d}, {4'h8, a}, {4'h1, w},
			{1'b0, a[2:0], w}};
		@(posedge clk);
		acc_in <= a;
		port_val <= d;
		repeat (11) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 1000 && q.size() > 0; i++)
			@(posedge clk);
		@(negedge clk);
		check("queue", q.size(), 0);
		check("sat on", sat, 1);
		check("mask off", mask, 0);
		check("status", st, d);
		$display("Test transfers and modes done");
		poll <= 1'b1;
		repeat (40) @(negedge clk);
		check("mask on", mask, 1);
		check("sat off", sat, 0);
		check("poll", pl, 1);
		@(posedge clk);
		map_sel <= 1'b1;
		repeat (8) @(negedge clk);
		check("mode", mc, 1);
		$display("Test flags and mode done");
		summarize;
	end
endmodule
`default_nettype wire
